/* core/llc_pkg.sv */
package llc_pkg;

  // ----------------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------------
  localparam int PIX_W    = 16;
  localparam int COL_W    = 12;
  localparam int MAX_COLS = 4096;
  localparam int ROW_W    = 16;
  localparam int FRAC_W   = 4;
  localparam int MODE_W   = 2;

  // ----------------------------------------------------------------------
  // Video modes
  // ----------------------------------------------------------------------
  localparam logic [MODE_W-1:0] MODE_PROC_SIDE = 2'h0;
  localparam logic [MODE_W-1:0] MODE_RAW_SIDE  = 2'h1;
  localparam logic [MODE_W-1:0] MODE_PROFILE   = 2'h2;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [PIX_W-1:0] PIX_RST   = 16'h0000;
  localparam logic [COL_W-1:0] COL_RST   = 12'h000;
  localparam logic [ROW_W-1:0] ROW_RST   = 16'h0000;
  localparam logic [15:0]      LINE_RST  = 16'h0000;
  localparam logic [7:0]       BYTE_RST  = 8'h00;

  // ----------------------------------------------------------------------
  // Result emission states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    LLC_IDLE = 2'b00,
    LLC_LO   = 2'b01,
    LLC_HI   = 2'b10,
    LLC_WORD = 2'b11
  } llc_state_t;

endpackage

/* core/llc_pix_if.sv */
`timescale 1ns/1ps
interface llc_pix_if;
  import llc_pkg::*;

  logic             valid;
  logic             sof;
  logic             sol;
  logic             eof;
  logic [PIX_W-1:0] data;
  logic [COL_W-1:0] col;

  modport src (output valid, sof, sol, eof, data, col);
  modport snk (input  valid, sof, sol, eof, data, col);
endinterface

/* core/llc_clamp.sv */
`timescale 1ns/1ps
module llc_clamp
  import llc_pkg::*;
(
  // Clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  // Pixel streams
  llc_pix_if.snk                pix_in,
  llc_pix_if.src                pix_out,
  // Thresholds
  input  wire logic [PIX_W-1:0] left_floor_level_i,
  input  wire logic [PIX_W-1:0] right_floor_level_i,
  input  wire logic [COL_W-1:0] floor_split_column_i,
  input  wire logic [PIX_W-1:0] ceiling_level_i
);

  logic [PIX_W-1:0] floor_sel;
  logic [PIX_W-1:0] next_data;

  always_comb begin
    floor_sel = (pix_in.col < floor_split_column_i) ?
                left_floor_level_i : right_floor_level_i; // RQ16
    if (pix_in.data < floor_sel) begin
      next_data = PIX_RST; // RQ2
    end else if (pix_in.data > ceiling_level_i) begin
      next_data = ceiling_level_i; // RQ3 RQ18
    end else begin
      next_data = pix_in.data;
    end
  end

  // Every pixel is clamped one stage ahead of the cluster search.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pix_out.valid <= 1'b0;
      pix_out.sof   <= 1'b0;
      pix_out.sol   <= 1'b0;
      pix_out.eof   <= 1'b0;
      pix_out.data  <= PIX_RST;
      pix_out.col   <= COL_RST;
    end else begin
      pix_out.valid <= pix_in.valid; // RQ4
      pix_out.sof   <= pix_in.valid & pix_in.sof;
      pix_out.sol   <= pix_in.valid & pix_in.sol;
      pix_out.eof   <= pix_in.valid & pix_in.eof;
      pix_out.data  <= next_data;
      pix_out.col   <= pix_in.col;
    end
  end

endmodule

/* core/llc_locator.sv */
`timescale 1ns/1ps
// Function
// RQ1 - Each column is handled alone and yields one 16-bit result.
// RQ2 - Pixels under the active floor level become zero.
// RQ3 - Pixels above the ceiling level become the ceiling level.
// RQ4 - Clamping happens before the column cluster search.
// RQ5 - Clusters are runs of adjacent non-zero pixels in a column.
// RQ6 - Only the largest cluster counts; its centre is the result.
// RQ7 - Result is fixed point with fractional_bit_count fraction bits.
// RQ8 - Results are unsigned 16-bit words.
// RQ9 - Mode 0: processed pixels, full frame out, profile as side payload.
// RQ10 - Mode 1: raw pixels, full frame out, profile as side payload.
// RQ11 - Mode 2: profile alone is the video stream, one word per column.
// RQ12 - Mode 2 input is processed for MONO16, raw for RAW16.
// RQ13 - Positions count from the top row of the region of interest.
// RQ14 - Combiner packs a set number of profiles per frame, one per row.
// RQ15 - Combiner never drops a profile between packed frames.
// RQ16 - Columns below split use left floor, others right floor.
// RQ17 - Side payload sends each result low byte first, then high byte.
// RQ18 - Ceiling at its maximum leaves pixel values unchanged.
// RQ19 - A column with no non-zero pixel yields zero.
module llc_locator
  import llc_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  // Processed pixel stream
  input  wire logic              proc_valid_i,
  input  wire logic              proc_sof_i,
  input  wire logic              proc_sol_i,
  input  wire logic              proc_eof_i,
  input  wire logic [PIX_W-1:0]  proc_data_i,
  // Raw sensor pixel stream
  input  wire logic              raw_valid_i,
  input  wire logic              raw_sof_i,
  input  wire logic              raw_sol_i,
  input  wire logic              raw_eof_i,
  input  wire logic [PIX_W-1:0]  raw_data_i,
  // Configuration
  input  wire logic [MODE_W-1:0] video_mode_i,
  input  wire logic              raw16_coding_i,
  input  wire logic [FRAC_W-1:0] fractional_bit_count_i,
  input  wire logic [PIX_W-1:0]  left_floor_level_i,
  input  wire logic [PIX_W-1:0]  right_floor_level_i,
  input  wire logic [COL_W-1:0]  floor_split_column_i,
  input  wire logic [PIX_W-1:0]  ceiling_level_i,
  input  wire logic [15:0]       lines_per_packed_frame_i,
  // Main video stream
  output logic                   vid_valid_o,
  output logic                   vid_sof_o,
  output logic                   vid_sol_o,
  output logic                   vid_eof_o,
  output logic [PIX_W-1:0]       vid_data_o,
  // Per-frame side payload
  output logic                   side_valid_o,
  output logic [7:0]             side_byte_o,
  output logic                   side_last_o,
  // Status
  output logic                   busy_o
);

  // ----------------------------------------------------------------------
  // Shared decoding
  // ----------------------------------------------------------------------
  function automatic logic is_profile(logic [MODE_W-1:0] mode);
    return mode == MODE_PROFILE;
  endfunction

  function automatic logic is_side_byte(llc_state_t st);
    return (st == LLC_LO) || (st == LLC_HI);
  endfunction

  function automatic logic is_pack_end(logic [15:0] cnt,
                                       logic [15:0] last);
    return cnt >= last;
  endfunction

  // ----------------------------------------------------------------------
  // Input selection
  // ----------------------------------------------------------------------
  llc_pix_if pix_sel ();
  llc_pix_if pix_clr ();

  logic             use_raw;
  logic [COL_W-1:0] in_col;
  logic [COL_W-1:0] next_in_col;

  // Mode and coding must stay steady for the whole of a frame.
  assign use_raw = (video_mode_i == MODE_RAW_SIDE) ||
                   (is_profile(video_mode_i) &&
                    raw16_coding_i); // RQ9 RQ10 RQ12

  always_comb begin
    if (use_raw) begin
      pix_sel.valid = raw_valid_i;
      pix_sel.sof   = raw_sof_i;
      pix_sel.sol   = raw_sol_i;
      pix_sel.eof   = raw_eof_i;
      pix_sel.data  = raw_data_i;
    end else begin
      pix_sel.valid = proc_valid_i;
      pix_sel.sof   = proc_sof_i;
      pix_sel.sol   = proc_sol_i;
      pix_sel.eof   = proc_eof_i;
      pix_sel.data  = proc_data_i;
    end
    next_in_col = (pix_sel.sol | pix_sel.sof) ?
                  COL_RST : in_col + 12'h001;
    pix_sel.col = next_in_col;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_col <= COL_RST;
    end else if (pix_sel.valid) begin
      in_col <= next_in_col;
    end
  end

  llc_clamp u_clamp (
    .core_clk_i           (core_clk_i),
    .rst_n_i              (rst_n_i),
    .pix_in               (pix_sel),
    .pix_out              (pix_clr),
    .left_floor_level_i   (left_floor_level_i),
    .right_floor_level_i  (right_floor_level_i),
    .floor_split_column_i (floor_split_column_i),
    .ceiling_level_i      (ceiling_level_i)
  );

  // ----------------------------------------------------------------------
  // Row tracking
  // ----------------------------------------------------------------------
  logic [ROW_W-1:0] row;
  logic [ROW_W-1:0] cur_row;
  logic [COL_W-1:0] ncols;

  // Row 0 is the first row delivered, the top of the region.
  assign cur_row = pix_clr.sof ? ROW_RST :
                   (pix_clr.sol ? row + 16'h0001 : row); // RQ13

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      row <= ROW_RST;
    end else if (pix_clr.valid) begin
      row <= cur_row;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ncols <= COL_RST;
    end else if (pix_clr.eof) begin
      ncols <= pix_clr.col;
    end
  end

  // ----------------------------------------------------------------------
  // Per-column cluster memory
  // ----------------------------------------------------------------------
  logic [ROW_W-1:0] run_start  [MAX_COLS];
  logic [ROW_W-1:0] run_len    [MAX_COLS];
  logic [ROW_W-1:0] best_start [MAX_COLS];
  logic [ROW_W-1:0] best_len   [MAX_COLS];

  logic [ROW_W-1:0] rd_run_len;
  logic [ROW_W-1:0] rd_best_len;
  logic             hit;
  logic             close_run;

  // Stale data from the previous frame is masked on row 0.
  always_comb begin
    rd_run_len  = (cur_row == ROW_RST) ? ROW_RST : run_len[pix_clr.col];
    rd_best_len = (cur_row == ROW_RST) ? ROW_RST : best_len[pix_clr.col];
    hit         = pix_clr.data != PIX_RST; // RQ5
    close_run   = !hit && (rd_run_len > rd_best_len); // RQ6
  end

  always_ff @(posedge core_clk_i) begin
    if (pix_clr.valid) begin
      if (hit) begin
        if (rd_run_len == ROW_RST) begin
          run_start[pix_clr.col] <= cur_row; // RQ5
        end
        run_len[pix_clr.col] <= rd_run_len + 16'h0001; // RQ5
      end else begin
        run_len[pix_clr.col] <= ROW_RST;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (pix_clr.valid) begin
      if (close_run) begin
        best_start[pix_clr.col] <= run_start[pix_clr.col]; // RQ6
        best_len[pix_clr.col]   <= rd_run_len;
      end else begin
        best_len[pix_clr.col]   <= rd_best_len;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Result computation
  // ----------------------------------------------------------------------
  logic [COL_W-1:0] emit_col;
  logic [ROW_W-1:0] sel_start;
  logic [ROW_W-1:0] sel_len;
  logic [16:0]      centre_x2;
  logic [31:0]      scaled;
  logic [15:0]      result;

  // A run still open at the bottom row is weighed here.
  always_comb begin
    if (run_len[emit_col] > best_len[emit_col]) begin
      sel_start = run_start[emit_col];
      sel_len   = run_len[emit_col];
    end else begin
      sel_start = best_start[emit_col];
      sel_len   = best_len[emit_col];
    end
    centre_x2 = {sel_start, 1'b0} + {1'b0, sel_len} - 17'h00001; // RQ6
    scaled    = ({15'h0000, centre_x2} << fractional_bit_count_i) >> 1;
    result    = (sel_len == ROW_RST) ? 16'h0000 : scaled[15:0]; // RQ7 RQ19
  end

  // ----------------------------------------------------------------------
  // Emission of one result per column
  // ----------------------------------------------------------------------
  llc_state_t       state;
  logic [15:0]      line_cnt;
  logic [15:0]      lines_last;
  logic             last_col;

  assign last_col   = emit_col == ncols;
  assign lines_last = (lines_per_packed_frame_i == LINE_RST) ?
                      LINE_RST : lines_per_packed_frame_i - 16'h0001;

  // Results are emitted in the blanking after the frame's last pixel.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state    <= LLC_IDLE;
      emit_col <= COL_RST;
    end else begin
      unique case (state)
        LLC_IDLE: begin
          emit_col <= COL_RST;
          if (pix_clr.eof) begin
            state <= is_profile(video_mode_i) ?
                     LLC_WORD : LLC_LO; // RQ1 RQ11
          end
        end
        LLC_LO: begin
          state <= LLC_HI; // RQ17
        end
        LLC_HI: begin
          emit_col <= emit_col + 12'h001;
          state    <= last_col ? LLC_IDLE : LLC_LO; // RQ1
        end
        LLC_WORD: begin
          emit_col <= emit_col + 12'h001;
          state    <= last_col ? LLC_IDLE : LLC_WORD; // RQ1
        end
      endcase
    end
  end

  // The packed-row counter steps once per profile and wraps after the last row, so no profile is skipped.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_cnt <= LINE_RST;
    end else if ((state == LLC_WORD) && last_col) begin
      line_cnt <= is_pack_end(line_cnt, lines_last) ?
                  LINE_RST : line_cnt + 16'h0001; // RQ14 RQ15
    end
  end

  // ----------------------------------------------------------------------
  // Side payload
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      side_valid_o <= 1'b0;
      side_byte_o  <= BYTE_RST;
      side_last_o  <= 1'b0;
    end else begin
      side_valid_o <= is_side_byte(state); // RQ9 RQ10
      // Between payload bytes the lane rests at zero, not at unwritten memory.
      if (!is_side_byte(state)) begin
        side_byte_o <= BYTE_RST;
      end else if (state == LLC_HI) begin
        side_byte_o <= result[15:8]; // RQ17
      end else begin
        side_byte_o <= result[7:0]; // RQ17
      end
      side_last_o  <= (state == LLC_HI) && last_col;
    end
  end

  // ----------------------------------------------------------------------
  // Main video stream
  // ----------------------------------------------------------------------
  logic pass_frame;

  assign pass_frame = !is_profile(video_mode_i);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vid_valid_o <= 1'b0;
      vid_sof_o   <= 1'b0;
      vid_sol_o   <= 1'b0;
      vid_eof_o   <= 1'b0;
      vid_data_o  <= PIX_RST;
    end else if (state == LLC_WORD) begin
      vid_valid_o <= 1'b1; // RQ11
      vid_sof_o   <= (emit_col == COL_RST) && (line_cnt == LINE_RST);
      vid_sol_o   <= emit_col == COL_RST; // RQ14
      vid_eof_o   <= last_col && is_pack_end(line_cnt, lines_last);
      vid_data_o  <= result; // RQ8
    end else if (pass_frame) begin
      vid_valid_o <= pix_sel.valid; // RQ9 RQ10
      vid_sof_o   <= pix_sel.valid & pix_sel.sof;
      vid_sol_o   <= pix_sel.valid & (pix_sel.sol | pix_sel.sof);
      vid_eof_o   <= pix_sel.valid & pix_sel.eof;
      vid_data_o  <= pix_sel.data;
    end else begin
      vid_valid_o <= 1'b0; // RQ11
      vid_sof_o   <= 1'b0;
      vid_sol_o   <= 1'b0;
      vid_eof_o   <= 1'b0;
      vid_data_o  <= PIX_RST;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= (state != LLC_IDLE) || pix_clr.eof;
    end
  end

endmodule

/* bench/llc_locator_chk.sv */
`timescale 1ns/1ps
module llc_locator_chk
  import llc_pkg::*;
(
  // Clock and reset
  input wire logic              core_clk_i,
  input wire logic              rst_n_i,
  // Pixel inputs
  input wire logic              proc_valid_i,
  input wire logic              proc_sof_i,
  input wire logic              proc_eof_i,
  input wire logic [PIX_W-1:0]  proc_data_i,
  input wire logic              raw_valid_i,
  input wire logic              raw_sof_i,
  input wire logic              raw_eof_i,
  input wire logic [PIX_W-1:0]  raw_data_i,
  input wire logic [MODE_W-1:0] video_mode_i,
  input wire logic              raw16_coding_i,
  // Outputs
  input wire logic              vid_valid_o,
  input wire logic              vid_sof_o,
  input wire logic              vid_sol_o,
  input wire logic [PIX_W-1:0]  vid_data_o,
  input wire logic              side_valid_o,
  input wire logic              side_last_o,
  input wire logic              busy_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  logic raw_sel;
  logic eof_sel;
  assign raw_sel = video_mode_i == MODE_RAW_SIDE ||
                   (video_mode_i == MODE_PROFILE && raw16_coding_i);
  assign eof_sel = raw_sel ? raw_valid_i && raw_eof_i
                           : proc_valid_i && proc_eof_i;

  sequence s_pair;
    side_valid_o ##1 side_valid_o;
  endsequence
  sequence s_row_start;
    vid_valid_o && vid_sol_o;
  endsequence

  a_proc_pass: assert property (video_mode_i == MODE_PROC_SIDE
    && proc_valid_i |=> vid_valid_o && vid_data_o == $past(proc_data_i)
    && vid_sof_o == $past(proc_sof_i)) else $error("proc pixel lost");
  a_raw_pass: assert property (video_mode_i == MODE_RAW_SIDE
    && raw_valid_i |=> vid_valid_o && vid_data_o == $past(raw_data_i)
    && vid_sof_o == $past(raw_sof_i)) else $error("raw pixel lost");
  a_prof_quiet: assert property (video_mode_i == MODE_PROFILE
    && (proc_valid_i || raw_valid_i) |=> !vid_valid_o)
    else $error("pixel leaked in profile mode");
  a_side_start: assert property (eof_sel
    && video_mode_i != MODE_PROFILE |-> ##3 s_pair)
    else $error("side payload late");
  a_prof_start: assert property (eof_sel
    && video_mode_i == MODE_PROFILE |-> ##3 s_row_start)
    else $error("profile line late");
  a_last_pair: assert property (side_last_o
    |-> side_valid_o && $past(side_valid_o)) else $error("lone last byte");
  a_side_pace: assert property (side_valid_o && !side_last_o
    |=> side_valid_o) else $error("payload gap");
  a_busy_emit: assert property (side_valid_o
    || (video_mode_i == MODE_PROFILE && vid_valid_o) |-> busy_o)
    else $error("result out while not busy");
  a_reset_quiet: assert property (disable iff (1'b0) !rst_n_i
    |-> !vid_valid_o && !side_valid_o && !busy_o)
    else $error("output active in reset");
endmodule

bind llc_locator llc_locator_chk u_chk (.*);

/* bench/llc_sink_model.sv */
`timescale 1ns/1ps
module llc_sink_model
  import llc_pkg::*;
(
  // Clock
  input wire logic             core_clk_i,
  // Streams from the locator
  input wire logic             vid_valid_o,
  input wire logic             vid_sof_o,
  input wire logic             vid_sol_o,
  input wire logic             vid_eof_o,
  input wire logic [PIX_W-1:0] vid_data_o,
  input wire logic             side_valid_o,
  input wire logic [7:0]       side_byte_o,
  input wire logic             side_last_o
);
  // The transport never stalls, so every word is taken when offered.
  logic [18:0] vid_q[$];
  logic [8:0]  side_q[$];

  always @(posedge core_clk_i) begin
    if (vid_valid_o === 1'b1)
      vid_q.push_back({vid_sof_o, vid_sol_o, vid_eof_o, vid_data_o});
    if (side_valid_o === 1'b1)
      side_q.push_back({side_last_o, side_byte_o});
  end
endmodule

/* bench/llc_locator_test.sv */
`timescale 1ns/1ps
module llc_locator_test;
  import llc_pkg::*;
  localparam int C = 4;
  localparam int R = 8;
  // Frame row-major; per column twice the winning run centre.
  localparam logic [15:0] PIX [R*C] = '{
    16'h001e, 16'h000a, 16'h003c, 16'h0000,
    16'h001e, 16'h000a, 16'h003c, 16'h0000,
    16'h0013, 16'h000a, 16'h0000, 16'hffff,
    16'h0028, 16'h0013, 16'h0000, 16'hffff,
    16'h0028, 16'h000a, 16'h0046, 16'hffff,
    16'h0028, 16'h000a, 16'h0031, 16'h0033,
    16'h0000, 16'h000a, 16'h0046, 16'h0000,
    16'h0000, 16'h000a, 16'h0046, 16'h0000};
  localparam logic [15:0] S2 [C] = '{16'h0008, 16'h0000, 16'h0001, 16'h0007};

  logic              core_clk_i, rst_n_i;
  logic              proc_valid_i, proc_sof_i, proc_sol_i, proc_eof_i;
  logic              raw_valid_i, raw_sof_i, raw_sol_i, raw_eof_i;
  logic [PIX_W-1:0]  proc_data_i, raw_data_i;
  logic [MODE_W-1:0] video_mode_i;
  logic              raw16_coding_i;
  logic [FRAC_W-1:0] fractional_bit_count_i;
  logic [PIX_W-1:0]  left_floor_level_i, right_floor_level_i;
  logic [COL_W-1:0]  floor_split_column_i;
  logic [PIX_W-1:0]  ceiling_level_i;
  logic [15:0]       lines_per_packed_frame_i;
  logic              vid_valid_o, vid_sof_o, vid_sol_o, vid_eof_o;
  logic [PIX_W-1:0]  vid_data_o;
  logic              side_valid_o, side_last_o, busy_o;
  logic [7:0]        side_byte_o;
  int                error_cnt, n_tests, cyc;

  assign raw_sof_i = proc_sof_i;
  assign raw_sol_i = proc_sol_i;
  assign raw_eof_i = proc_eof_i;

  llc_locator    u_dut (.*);
  llc_sink_model u_sink (.*);

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic step(int n);
    repeat (n) @(posedge core_clk_i);
    #2;
  endtask

  task automatic chk(string nm, logic [18:0] e, logic [18:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  function automatic logic [15:0] res(int c, int d);
    return 16'((32'(S2[c]) << d) >> 1);
  endfunction

  // The stream not selected carries inverted data with valid low.
  task automatic frame(bit sel);
    u_sink.vid_q.delete();
    u_sink.side_q.delete();
    for (int i = 0; i < R*C; i++) begin
      proc_valid_i = !sel;
      raw_valid_i = sel;
      proc_sof_i = (i == 0);
      proc_sol_i = (i % C == 0);
      proc_eof_i = (i == R*C-1);
      proc_data_i = sel ? ~PIX[i] : PIX[i];
      raw_data_i = sel ? PIX[i] : ~PIX[i];
      step(1);
    end
    proc_valid_i = 0;
    raw_valid_i = 0;
    step(2*C+8);
  endtask

  // Side-payload modes also forward the whole frame untouched.
  task automatic chk_side(int d, bit flat);
    logic [15:0] v;
    chk("frame words", 19'(R*C), 19'(u_sink.vid_q.size()));
    for (int i = 0; i < R*C; i++) begin
      chk("frame word", {i == 0, i % C == 0, i == R*C-1, PIX[i]},
          u_sink.vid_q[i]);
    end
    chk("side count", 19'(2*C), 19'(u_sink.side_q.size()));
    for (int c = 0; c < C; c++) begin
      v = flat ? 16'h0000 : res(c, d);
      chk("side lo", 19'(v[7:0]), 19'(u_sink.side_q[2*c]));
      chk("side hi", 19'({c == C-1, v[15:8]}),
          19'(u_sink.side_q[2*c+1]));
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------------------------------------
  initial begin
    core_clk_i = 0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      stop_test();
    end
  end

  initial begin
    {proc_valid_i, proc_sof_i, proc_sol_i, proc_eof_i, raw_valid_i} = 5'h00;
    proc_data_i = 16'h0000;
    raw_data_i = 16'h0000;
    rst_n_i = 0;
    video_mode_i = MODE_PROFILE;
    raw16_coding_i = 0;
    fractional_bit_count_i = 4'hc;
    left_floor_level_i = 16'h0014;
    right_floor_level_i = 16'h0032;
    floor_split_column_i = 12'h002;
    ceiling_level_i = 16'h0100;
    lines_per_packed_frame_i = 16'h0002;
    step(4);
    rst_n_i = 1;
    // Four profile lines packed two per frame, coding changed halfway.
    for (int l = 0; l < 4; l++) begin
      raw16_coding_i = (l > 1);
      frame(l > 1);
      chk("line words", 19'(C), 19'(u_sink.vid_q.size()));
      for (int c = 0; c < C; c++) begin
        chk("profile word", {c == 0 && l % 2 == 0, c == 0,
            c == C-1 && l % 2 == 1, res(c, 12)}, u_sink.vid_q[c]);
      end
    end
    video_mode_i = MODE_PROC_SIDE;
    fractional_bit_count_i = 4'h4;
    ceiling_level_i = 16'hffff;
    frame(0);
    chk_side(4, 1'b0);
    video_mode_i = MODE_RAW_SIDE;
    fractional_bit_count_i = 4'h0;
    ceiling_level_i = 16'h0100;
    frame(1);
    chk_side(0, 1'b0);
    // A zero ceiling flattens every pixel, so each column reports zero.
    ceiling_level_i = 16'h0000;
    frame(1);
    chk_side(0, 1'b1);
    stop_test();
  end
endmodule
